// ==== reset_strap_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module reset_strap_sequencer #(
    parameter int unsigned SHORT_CYC = rst_seq_pkg::SHORT_DELAY_CYC,
    parameter int unsigned LONG_CYC  = rst_seq_pkg::LONG_DELAY_CYC
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_delay_strap_in,
    input  wire logic                    i_size_strap_in,
    input  wire logic                    i_addr25,
    input  wire logic                    i_addr26,
    input  wire logic                    i_major_reset,
    input  wire logic                    i_boot_select_n,
    input  wire rst_seq_pkg::high_pins_t i_high_pins,
    output logic                         o_delay_strap_out,
    output logic                         o_delay_strap_oe,
    output logic                         o_size_strap_out,
    output logic                         o_size_strap_oe,
    output logic                         o_delay_strap_pull_up,
    output logic                         o_size_strap_pull_up,
    output logic [3:0]                   o_high_out,
    output logic [3:0]                   o_high_oe,
    output logic                         o_boot_select_n,
    output logic                         o_bus_16bit,
    output logic                         o_long_delay,
    output logic                         o_major_proc,
    output logic                         o_minor_proc,
    output logic                         o_core_run,
    output logic                         o_reset_out_n
);
    import rst_seq_pkg::*;

    // ======================================================
    // State
    typedef struct packed {
        seq_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic              long_dly;
        logic              bus16;
        logic              major;
        logic              rst_out_n;
        logic              a25;
        logic              a26;
        logic              boot_n;
        logic              core_run;
        logic              major_proc;
        logic              minor_proc;
    } seq_t;

    seq_t             state;
    seq_t             next_state;
    pin_drive_t       high_drive;
    logic             run;
    logic [CNT_W-1:0] delay_last;
    logic             delay_done;
    logic             proc_done;

    assign run = state.core_run;

    // ======================================================
    // Count limits
    // Both ends are cut to the counter width on purpose; the
    // longest default delay still fits in it.
    assign delay_last = state.long_dly ? CNT_W'(LONG_CYC - 1)
                                       : CNT_W'(SHORT_CYC - 1);
    assign delay_done = (state.cnt == delay_last);
    assign proc_done  = (state.cnt == CNT_W'(PROC_CYC - 1));

    // ======================================================
    // Sequencer
    // The straps are caught on the first clock after reset release,
    // since an asynchronous reset may only load constants.
    always_comb begin
        next_state = state;
        case (state.st)
            ST_HOLD: begin
                next_state.long_dly = i_delay_strap_in;
                next_state.bus16    = i_size_strap_in;
                next_state.cnt      = '0;
                next_state.st       = ST_DELAY;
            end

            ST_DELAY: begin
                next_state.cnt = state.cnt + 1'b1;
                if (delay_done) begin
                    next_state.cnt   = '0;
                    next_state.major = i_major_reset;
                    next_state.st    = ST_PROC;
                end
            end

            ST_PROC: begin
                next_state.cnt = state.cnt + 1'b1;
                if (proc_done) begin
                    next_state.rst_out_n = 1'b1;
                    next_state.st        = ST_RUN;
                end
            end

            ST_RUN: begin
                next_state.cnt = '0;
            end

            default: begin
                next_state.st = ST_HOLD;
            end
        endcase
        // Straps only become address outputs once running
        next_state.a25    = i_addr25;
        next_state.a26    = i_addr26;
        next_state.boot_n = run ? i_boot_select_n : 1'b0;
        // Status copies are registered so no state decode glitch
        // can reach a pin
        next_state.core_run   = (next_state.st == ST_RUN);
        next_state.major_proc = (next_state.st == ST_PROC) &&
                                next_state.major;
        next_state.minor_proc = (next_state.st == ST_PROC) &&
                                !next_state.major;
    end

    // ======================================================
    // Registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state.st         <= ST_HOLD;
            state.cnt        <= '0;
            state.long_dly   <= LONG_RST;
            state.bus16      <= BUS16_RST;
            state.major      <= 1'b1;
            state.rst_out_n  <= 1'b0;
            state.a25        <= 1'b0;
            state.a26        <= 1'b0;
            state.boot_n     <= 1'b0;
            state.core_run   <= 1'b0;
            state.major_proc <= 1'b0;
            state.minor_proc <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================
    // Shared high pins
    high_pin_mux u_high_pin_mux (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_run   (run),
        .i_pins  (i_high_pins),
        .o_drive (high_drive)
    );

    // ======================================================
    // Strap pins
    assign o_delay_strap_out     = state.a25;
    assign o_delay_strap_oe      = run;
    assign o_size_strap_out      = state.a26;
    assign o_size_strap_oe       = run;
    // Pull-ups stay on so an open strap reads high
    assign o_delay_strap_pull_up = 1'b1;
    assign o_size_strap_pull_up  = 1'b1;

    // ======================================================
    // Status
    assign o_high_out            = high_drive.out;
    assign o_high_oe             = high_drive.oe;
    assign o_boot_select_n       = state.boot_n;
    assign o_bus_16bit           = state.bus16;
    assign o_long_delay          = state.long_dly;
    assign o_major_proc          = state.major_proc;
    assign o_minor_proc          = state.minor_proc;
    assign o_core_run            = run;
    assign o_reset_out_n         = state.rst_out_n;
endmodule // reset_strap_sequencer
`default_nettype wire

// ==== rst_seq_pkg.sv ====
`default_nettype none
package rst_seq_pkg;

    // ======================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned SHORT_DELAY_US   = 100;
    localparam int unsigned LONG_DELAY_MS    = 20;
    localparam int unsigned SHORT_DELAY_CYC  =
        (SHORT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LONG_DELAY_CYC   =
        (LONG_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROC_CYC         = 4;
    localparam int unsigned CNT_W            = 22;

    // ======================================================
    // Reset values
    localparam logic        BUS16_RST        = 1'b1;
    localparam logic        LONG_RST         = 1'b1;
    localparam logic [3:0]  HIGH_OE_RST      = 4'h0;

    // ======================================================
    // Types
    typedef enum logic [3:0] {
        ST_HOLD  = 4'h1,
        ST_DELAY = 4'h2,
        ST_PROC  = 4'h4,
        ST_RUN   = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] sel_n;
        logic [3:0] use_select;
    } high_pins_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pin_drive_t;

endpackage
`default_nettype wire

// ==== high_pin_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
module high_pin_mux (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_run,
    input  wire rst_seq_pkg::high_pins_t i_pins,
    output var  rst_seq_pkg::pin_drive_t o_drive
);
    import rst_seq_pkg::*;

    typedef struct packed {
        pin_drive_t drive;
    } mux_state_t;

    mux_state_t state;
    mux_state_t next_state;

    // ======================================================
    // Pin select
    always_comb begin
        next_state = state;
        next_state.drive.oe = i_run ? 4'hF : HIGH_OE_RST;
        // Bit 0 is addr 27 / select 7, bit 3 is addr 30 / select 4
        for (int i = 0; i < 4; i++) begin
            next_state.drive.out[i] = i_pins.use_select[i] ?
                i_pins.sel_n[i] : i_pins.addr[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_drive = state.drive;
endmodule // high_pin_mux
`default_nettype wire

// ==== reset_strap_sequencer_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Sequencer checks
module reset_strap_sequencer_props #(
    parameter int unsigned SHORT_CYC = rst_seq_pkg::SHORT_DELAY_CYC,
    parameter int unsigned LONG_CYC  = rst_seq_pkg::LONG_DELAY_CYC
) (
    input wire logic                    i_clk,
    input wire logic                    i_rst_n,
    input wire logic                    i_boot_select_n,
    input wire rst_seq_pkg::high_pins_t i_high_pins,
    input wire logic [3:0]              o_high_out,
    input wire logic [3:0]              o_high_oe,
    input wire logic                    o_boot_select_n,
    input wire logic                    o_long_delay,
    input wire logic                    o_major_proc,
    input wire logic                    o_minor_proc,
    input wire logic                    o_core_run,
    input wire logic                    o_reset_out_n
);
    logic [31:0] cnt;
    logic [3:0]  mux_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt   <= '0;
            mux_q <= '0;
        end else begin
            cnt   <= cnt + 32'h1;
            mux_q <= (i_high_pins.use_select & i_high_pins.sel_n)
                   | (~i_high_pins.use_select & i_high_pins.addr);
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_proc; (o_major_proc ^ o_minor_proc) [*4]; endsequence
    sequence s_run; o_core_run && !(o_major_proc || o_minor_proc); endsequence
    property p_proc;
        $rose(o_major_proc || o_minor_proc) |-> s_proc ##1 s_run;
    endproperty
    a_proc: assert property (p_proc) else $error("bad processing");
    property p_delay; $rose(o_major_proc || o_minor_proc) |->
        cnt == (o_long_delay ? LONG_CYC : SHORT_CYC) + 1; endproperty
    a_delay: assert property (p_delay) else $error("bad delay");
    property p_float; !o_core_run |-> o_high_oe == 4'h0; endproperty
    a_float: assert property (p_float) else $error("pins driven");
    property p_boot; !o_core_run |-> !o_boot_select_n; endproperty
    a_boot: assert property (p_boot) else $error("boot off");
    property p_rout; o_reset_out_n == o_core_run; endproperty
    a_rout: assert property (p_rout) else $error("reset out");
    property p_keep; o_core_run |=> o_core_run; endproperty
    a_keep: assert property (p_keep) else $error("run lost");
    property p_mux; o_high_oe == 4'hF |-> o_high_out == mux_q; endproperty
    a_mux: assert property (p_mux) else $error("pin mux");
    property p_follow; o_high_oe == 4'hF |->
        o_boot_select_n == $past(i_boot_select_n); endproperty
    a_follow: assert property (p_follow) else $error("boot mux");
endmodule // reset_strap_sequencer_props
`default_nettype wire

// ==== strap_pin.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Board side of one strap pin
module strap_pin (
    input  wire logic i_clk,
    input  wire logic i_ext_en,
    input  wire logic i_ext_val,
    input  wire logic i_oe,
    input  wire logic i_out,
    input  wire logic i_pull_up,
    output logic      o_level
);
    logic last = 1'b0;
    always @(posedge i_clk) last <= o_level;
    // No pull: show the inverse so a stale level is never read back
    assign o_level = i_oe ? i_out : i_ext_en ? i_ext_val
                   : i_pull_up ? 1'b1 : ~last;
endmodule // strap_pin
`default_nettype wire

// ==== test_reset_strap_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench
module test_reset_strap_sequencer;
    import rst_seq_pkg::*;
    logic i_clk = 0, i_rst_n = 0, en = 1, dly = 0, sz = 0, maj = 1, bs = 1;
    logic a25 = 0, a26 = 0;
    high_pins_t hp = '{4'hA, 4'h3, 4'h5};
    wire logic din, sin, doe, dout, soe, sout, dpu, spu, bo, b16, lng;
    wire logic mj, mn, run, ro;
    wire logic [3:0] ho, hoe;
    int err_total = 0, tests_run = 0, cyc = 0, n;
    logic mjs, mns;
    // Row: drive enable, delay strap, size strap, major bit,
    // expected long delay, expected 16-bit bus
    logic [5:0] rows [5] = '{6'h3F, 6'h32, 6'h29, 6'h24, 6'h07};
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cyc > 2000) begin
        err_total++;
        end_sim();
    end
    strap_pin i_dp (.i_clk, .i_ext_en(en), .i_ext_val(dly), .i_oe(doe),
        .i_out(dout), .i_pull_up(dpu), .o_level(din));
    strap_pin i_sp (.i_clk, .i_ext_en(en), .i_ext_val(sz), .i_oe(soe),
        .i_out(sout), .i_pull_up(spu), .o_level(sin));
    reset_strap_sequencer #(.SHORT_CYC(8), .LONG_CYC(20)) i_dut (
        .i_clk, .i_rst_n, .i_delay_strap_in(din), .i_size_strap_in(sin),
        .i_addr25(a25), .i_addr26(a26), .i_major_reset(maj),
        .i_boot_select_n(bs), .i_high_pins(hp), .o_delay_strap_out(dout),
        .o_delay_strap_oe(doe), .o_size_strap_out(sout), .o_size_strap_oe(soe),
        .o_delay_strap_pull_up(dpu), .o_size_strap_pull_up(spu),
        .o_high_out(ho), .o_high_oe(hoe), .o_boot_select_n(bo),
        .o_bus_16bit(b16), .o_long_delay(lng), .o_major_proc(mj),
        .o_minor_proc(mn), .o_core_run(run), .o_reset_out_n(ro));
    task automatic chk(string nm, logic [9:0] got, logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic go(logic [5:0] r);
        @(posedge i_clk);
        i_rst_n <= 0;
        {en, dly, sz, maj} <= r[5:2];
        {a25, a26, bs} <= r[4:2];
        repeat (2) @(posedge i_clk);
        // Held only briefly: delays are scaled down and the block
        // needs no clock of reset
        i_rst_n <= 1;
        @(posedge i_clk);
        {dly, sz} <= ~r[4:3];
        {n, mjs, mns} = {32'h1, 2'h0};
        while (!run && n < 100) begin
            @(negedge i_clk);
            n++;
            mjs |= mj;
            mns |= mn;
        end
        chk("delay", n[9:0], r[1] ? 10'h01A : 10'h00E);
        chk("straps", {lng, b16}, r[1:0]);
        chk("proc", {mjs, mns}, {r[2], !r[2]});
        @(negedge i_clk);
        chk("pins", {hoe, ho}, 10'h0FB);
        chk("run", {bo, ro, doe, dout, soe, sout},
            {4'h0, r[2], 2'h3, r[4], 1'b1, r[3]});
    endtask
    initial begin
        foreach (rows[i]) go(rows[i]);
        @(posedge i_clk);
        i_rst_n <= 0;
        @(negedge i_clk);
        chk("reset", {run, ro, bo, hoe, b16, lng},
            10'h003);
        // Abort a sequence in its delay, then run a clean one
        @(posedge i_clk);
        i_rst_n <= 1;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        chk("abort", {run, ro, hoe}, 10'h000);
        go(6'h24);
        end_sim();
    end
endmodule // test_reset_strap_sequencer
bind reset_strap_sequencer reset_strap_sequencer_props #(
    .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) i_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_boot_select_n(i_boot_select_n),
    .i_high_pins(i_high_pins), .o_high_out(o_high_out),
    .o_high_oe(o_high_oe), .o_boot_select_n(o_boot_select_n),
    .o_long_delay(o_long_delay), .o_major_proc(o_major_proc),
    .o_minor_proc(o_minor_proc), .o_core_run(o_core_run),
    .o_reset_out_n(o_reset_out_n));
`default_nettype wire
